// ---- logic/tsr_pkg.sv ----
package tsr_pkg;

  // ****************************************************************
  // Register map (byte addresses on the bus)
  // ****************************************************************
  localparam logic [3:0] OFS_OWN_ADDR = 4'h0;
  localparam logic [3:0] OFS_CONTROL  = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h8;
  localparam logic [3:0] OFS_DATA     = 4'hC;

  // Control register bit positions
  localparam int CTL_FLAG_BIT  = 7;
  localparam int CTL_ACK_BIT   = 6;
  localparam int CTL_START_BIT = 5;
  localparam int CTL_STOP_BIT  = 4;
  localparam int CTL_EN_BIT    = 2;

  // Own address register layout and reset values
  localparam int          OWN_GC_BIT     = 0;
  localparam logic [7:0]  OWN_ADDR_RST   = 8'h00;
  localparam logic [6:0]  GEN_CALL_ADDR  = 7'h00;
  localparam logic [1:0]  PRESC_RST      = 2'h0;
  localparam logic [7:0]  DATA_RST       = 8'hFF;

  // Status codes, prescaler field taken as zero
  localparam logic [7:0] ST_IDLE       = 8'hF8;
  localparam logic [7:0] ST_START_SENT = 8'h08;
  localparam logic [7:0] ST_OWN_W      = 8'h60;
  localparam logic [7:0] ST_ARB_OWN_W  = 8'h68;
  localparam logic [7:0] ST_GC_W       = 8'h70;
  localparam logic [7:0] ST_ARB_GC_W   = 8'h78;
  localparam logic [7:0] ST_OWN_ACK    = 8'h80;
  localparam logic [7:0] ST_OWN_NACK   = 8'h88;
  localparam logic [7:0] ST_GC_ACK     = 8'h90;
  localparam logic [7:0] ST_GC_NACK    = 8'h98;
  localparam logic [7:0] ST_STOP_RX    = 8'hA0;
  localparam logic [7:0] STATUS_MASK   = 8'hF8;

  // Timing: start hold and stop setup of a generated condition
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_HOLD_NS     = 4000;
  localparam int T_HOLD_CYC    = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BITS_PER_BYTE = 8;

  // Control fields held by software
  typedef struct packed {
    logic ack_en;
    logic start_req;
    logic enable;
  } tsr_ctrl_t;

  // Own address fields
  typedef struct packed {
    logic [6:0] addr;
    logic       gc_en;
  } tsr_own_t;

  typedef enum {
    S_IDLE, S_ADDR, S_ACK_A, S_DATA, S_ACK_D, S_WAIT, S_NOTME, S_MSTART, S_MHOLD, S_MSTOP
  } tsr_state_t;

endpackage

// ---- logic/tsr_slave_rx.sv ----
`timescale 1ns/10ps
module tsr_slave_rx
  import tsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        deep_sleep,
  output logic             wake_req
);

  // ****************************************************************
  // Bus line synchronisers and condition detection
  // ****************************************************************
  logic       scl_s1_ff;
  logic       scl_s2_ff;
  logic       scl_s3_ff;
  logic       sda_s1_ff;
  logic       sda_s2_ff;
  logic       sda_s3_ff;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  // Two flops per line; third flop only gives the edge history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  // Data edges while clock high are start and stop conditions
  assign scl_rise   = scl_s2_ff & ~scl_s3_ff;
  assign scl_fall   = ~scl_s2_ff & scl_s3_ff;
  assign start_seen = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
  assign stop_seen  = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  tsr_ctrl_t  ctrl_ff;
  tsr_own_t   own_ff;
  logic       flag_ff;
  logic [7:0] status_ff;
  logic [1:0] presc_ff;
  logic [7:0] data_ff;
  logic       bus_ack_ff;
  logic       wr_now;
  logic       wr_ok;
  logic       flag_clr;
  logic       flag_set;
  logic [7:0] nxt_status;
  logic [7:0] nxt_rdata;

  // One wait cycle per access; read data registers on the first edge, writes land on the second
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_ff;
  assign wr_now          = avs_write & bus_ack_ff & avs_byteenable[0];
  assign wr_ok           = wr_now & (avs_address[1:0] == 2'h0);
  assign flag_clr        = wr_ok & (avs_address == OFS_CONTROL)
                           & avs_writedata[CTL_FLAG_BIT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack_ff <= 1'b0;
    end else begin
      bus_ack_ff <= (avs_read | avs_write) & ~bus_ack_ff;
    end
  end

  // Read mux; misaligned or unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (avs_address)
      OFS_OWN_ADDR: nxt_rdata = own_ff;
      OFS_CONTROL:  nxt_rdata = {flag_ff, ctrl_ff.ack_en, ctrl_ff.start_req,
                                 1'b0, 1'b0, ctrl_ff.enable, 2'b00};
      OFS_STATUS:   nxt_rdata = {status_ff[7:3], 1'b0, presc_ff};
      OFS_DATA:     nxt_rdata = data_ff;
      default:      nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~bus_ack_ff) begin
      avs_readdata <= {24'h00_0000, nxt_rdata};
    end
  end

  // Own address and prescaler, plain storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      own_ff   <= OWN_ADDR_RST;
      presc_ff <= PRESC_RST;
    end else if (wr_ok & (avs_address == OFS_OWN_ADDR)) begin
      own_ff   <= avs_writedata[7:0];
    end else if (wr_ok & (avs_address == OFS_STATUS)) begin
      presc_ff <= avs_writedata[1:0];
    end
  end

  // ****************************************************************
  // Receive state machine
  // ****************************************************************
  tsr_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic       gc_mode_ff;
  logic       leaving_ff;
  logic       acked_ff;
  logic       slept_ff;
  logic       busy_ff;
  logic [7:0] hold_cnt_ff;
  logic       own_hit;
  logic       gc_hit;
  logic       addr_done;
  logic       data_done;
  logic       addressed;
  logic       start_clr;

  // Address decode; acknowledge enable gates all recognition
  assign own_hit   = ctrl_ff.enable & ctrl_ff.ack_en
                     & (shift_ff[7:1] == own_ff.addr);
  assign gc_hit    = ctrl_ff.enable & ctrl_ff.ack_en & own_ff.gc_en
                     & (shift_ff[7:1] == GEN_CALL_ADDR);
  assign addr_done = (state_ff == S_ADDR) & scl_fall & (bit_cnt_ff == 4'(BITS_PER_BYTE));
  assign data_done = (state_ff == S_DATA) & scl_fall & (bit_cnt_ff == 4'(BITS_PER_BYTE));
  assign addressed = (state_ff == S_DATA) | (state_ff == S_ACK_D)
                     | (state_ff == S_ACK_A);

  // Flag set events; a set in the clearing cycle wins
  assign flag_set  = ((state_ff == S_ACK_A) | (state_ff == S_ACK_D)) & scl_fall
                     | (addressed & (start_seen | stop_seen))
                     | ((state_ff == S_MSTART) & (hold_cnt_ff == 8'h00));

  // Start request is dropped once a start has gone out
  assign start_clr = (state_ff == S_MSTART) & (hold_cnt_ff == 8'h00);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= '0;
    end else if (wr_ok & (avs_address == OFS_CONTROL)) begin
      ctrl_ff.ack_en    <= avs_writedata[CTL_ACK_BIT];
      ctrl_ff.start_req <= avs_writedata[CTL_START_BIT];
      ctrl_ff.enable    <= avs_writedata[CTL_EN_BIT];
    end else if (start_clr) begin
      ctrl_ff.start_req <= 1'b0;
    end
  end

  // Event flag, cleared by writing one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= flag_set | (flag_ff & ~flag_clr);
    end
  end

  // Status code for the event being posted
  always_comb begin
    nxt_status = status_ff;
    if (addressed & (start_seen | stop_seen)) begin
      nxt_status = ST_STOP_RX;
    end else if ((state_ff == S_ACK_A) & scl_fall) begin
      case ({gc_mode_ff, ctrl_ff.start_req})
        2'b00:   nxt_status = ST_OWN_W;
        2'b01:   nxt_status = ST_ARB_OWN_W;
        2'b10:   nxt_status = ST_GC_W;
        default: nxt_status = ST_ARB_GC_W;
      endcase
    end else if ((state_ff == S_ACK_D) & scl_fall) begin
      case ({gc_mode_ff, acked_ff})
        2'b01:   nxt_status = ST_OWN_ACK;
        2'b00:   nxt_status = ST_OWN_NACK;
        2'b11:   nxt_status = ST_GC_ACK;
        default: nxt_status = ST_GC_NACK;
      endcase
    end else if (start_clr) begin
      nxt_status = ST_START_SENT;
    end else if (flag_clr & ~flag_set) begin
      nxt_status = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_ff <= ST_IDLE;
    end else begin
      status_ff <= nxt_status & STATUS_MASK;
    end
  end

  // Bus busy between start and stop, for start generation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
    end else if (start_seen) begin
      busy_ff <= 1'b1;
    end else if (stop_seen) begin
      busy_ff <= 1'b0;
    end
  end

  // Bit shifter; address bytes never reach the data register,
  // so after a sleep wake it still holds an older byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_ff   <= 8'h00;
      bit_cnt_ff <= 4'h0;
      data_ff    <= DATA_RST;
    end else begin
      if (start_seen | (state_ff == S_WAIT) | (state_ff == S_ACK_A)
          | (state_ff == S_ACK_D)) begin
        bit_cnt_ff <= 4'h0;
      end else if (scl_rise & (bit_cnt_ff < 4'(BITS_PER_BYTE))) begin
        shift_ff   <= {shift_ff[6:0], sda_s2_ff};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      if (data_done) begin
        data_ff <= shift_ff;
      end
    end
  end

  // Main sequencing; hold count shared by start and stop generation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= S_IDLE;
      gc_mode_ff  <= 1'b0;
      leaving_ff  <= 1'b0;
      acked_ff    <= 1'b0;
      hold_cnt_ff <= 8'h00;
    end else if (!ctrl_ff.enable) begin
      state_ff    <= S_IDLE;
      leaving_ff  <= 1'b0;
    end else if ((start_seen | stop_seen) & (state_ff != S_MSTART)
                 & (state_ff != S_MSTOP) & (state_ff != S_MHOLD)) begin
      state_ff    <= start_seen ? S_ADDR : S_IDLE;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (ctrl_ff.start_req & ~busy_ff & ~flag_ff) begin
            state_ff    <= S_MSTART;
            hold_cnt_ff <= 8'(T_HOLD_CYC);
          end
        end
        S_ADDR: begin
          if (addr_done) begin
            if ((own_hit | gc_hit) & ~shift_ff[0]) begin
              state_ff   <= S_ACK_A;
              gc_mode_ff <= ~own_hit;
            end else begin
              state_ff   <= S_NOTME;
            end
          end
        end
        S_ACK_A: begin
          if (scl_fall) begin
            state_ff   <= S_WAIT;
            leaving_ff <= 1'b0;
          end
        end
        S_DATA: begin
          if (data_done) begin
            state_ff <= S_ACK_D;
            acked_ff <= ctrl_ff.ack_en;
          end
        end
        S_ACK_D: begin
          if (scl_fall) begin
            state_ff   <= S_WAIT;
            leaving_ff <= ~acked_ff;
          end
        end
        S_WAIT: begin
          if (!flag_ff) begin
            state_ff <= leaving_ff ? S_NOTME : S_DATA;
          end
        end
        S_MSTART: begin
          if (hold_cnt_ff != 8'h00) begin
            hold_cnt_ff <= hold_cnt_ff - 8'h01;
          end else begin
            state_ff <= S_MHOLD;
          end
        end
        S_MHOLD: begin
          if (!flag_ff) begin
            state_ff    <= S_MSTOP;
            hold_cnt_ff <= 8'(T_HOLD_CYC);
          end
        end
        S_MSTOP: begin
          if (hold_cnt_ff != 8'h00) begin
            hold_cnt_ff <= hold_cnt_ff - 8'h01;
          end else begin
            state_ff <= S_IDLE;
          end
        end
        S_NOTME: state_ff <= S_NOTME;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drive and wake-up
  // ****************************************************************
  logic       nxt_sda_oe;
  logic       nxt_scl_oe;

  // Acknowledge slot drives data low; NACK simply leaves it released
  always_comb begin
    nxt_sda_oe = 1'b0;
    nxt_scl_oe = 1'b0;
    case (state_ff)
      S_ACK_A: nxt_sda_oe = 1'b1;
      S_ACK_D: nxt_sda_oe = acked_ff;
      S_WAIT:  nxt_scl_oe = flag_ff;
      S_MSTART: nxt_sda_oe = 1'b1;
      S_MHOLD: begin
        nxt_sda_oe = 1'b1;
        nxt_scl_oe = 1'b1;
      end
      S_MSTOP: nxt_sda_oe = 1'b1;
      default: begin
        nxt_sda_oe = 1'b0;
        nxt_scl_oe = 1'b0;
      end
    endcase
  end

  // Registered enables avoid glitches on the open-drain lines
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      sda_oe <= nxt_sda_oe;
      scl_oe <= nxt_scl_oe;
    end
  end

  assign sda_o = 1'b0;
  assign scl_o = 1'b0;

  // Address taken while asleep: ask for wake-up until flag is cleared.
  // A long wake-up keeps the clock line low and blocks the whole bus.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      slept_ff <= 1'b0;
    end else if ((state_ff == S_ACK_A) & scl_fall & deep_sleep) begin
      slept_ff <= 1'b1;
    end else if (!flag_ff) begin
      slept_ff <= 1'b0;
    end
  end

  assign wake_req = slept_ff & flag_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence ack_slot_s;
    (state_ff == S_ACK_A) ##1 sda_oe;
  endsequence

  sequence post_own_s;
    flag_ff && (status_ff == ST_OWN_W);
  endsequence

  a_status_masked: assert property (@(posedge clk) disable iff (!rstn)
    status_ff[2:0] == 3'h0)
    else $error("status low bits not zero");

  a_own_addr_ack: assert property (@(posedge clk) disable iff (!rstn)
    (addr_done && own_hit && !shift_ff[0] && !ctrl_ff.start_req) |=> ack_slot_s)
    else $error("own address not acknowledged");

  a_gc_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (addr_done && !own_hit && !own_ff.gc_en) |=> (state_ff == S_NOTME))
    else $error("general call taken while disabled");

  a_own_code: assert property (@(posedge clk) disable iff (!rstn)
    ((state_ff == S_ACK_A) && scl_fall && !gc_mode_ff && !ctrl_ff.start_req)
    |=> post_own_s)
    else $error("own address code not posted");

  a_nack_data: assert property (@(posedge clk) disable iff (!rstn)
    (data_done && !ctrl_ff.ack_en) |=> ##1 !sda_oe [*2])
    else $error("data acknowledged while disabled");

  a_nack_code: assert property (@(posedge clk) disable iff (!rstn)
    ((state_ff == S_ACK_D) && scl_fall && !acked_ff && !gc_mode_ff)
    |=> flag_ff && (status_ff == ST_OWN_NACK))
    else $error("not-acknowledge code missing");

  a_stop_code: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl_ff.enable && addressed && stop_seen)
    |=> (status_ff == ST_STOP_RX) && flag_ff && (state_ff == S_IDLE))
    else $error("stop while addressed not reported");

  a_stretch_hold: assert property (@(posedge clk) disable iff (!rstn)
    ((state_ff == S_WAIT) && flag_ff && $past(flag_ff)) |-> scl_oe)
    else $error("clock not stretched while flag set");

  a_wake_stretch: assert property (@(posedge clk) disable iff (!rstn)
    (wake_req && $past(wake_req) && (state_ff == S_WAIT)) |-> scl_oe)
    else $error("wake-up without clock stretch");

  a_start_gen: assert property (@(posedge clk) disable iff (!rstn)
    ((state_ff == S_IDLE) && ctrl_ff.enable && ctrl_ff.start_req && !busy_ff
     && !flag_ff && !start_seen && !stop_seen)
    |=> ##1 sda_oe && !scl_oe)
    else $error("start condition not driven");

endmodule

// ---- sim/tsr_bus_master.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Two-wire master transmitter; open-drain pulls only
// ****************************************************************
module tsr_bus_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // Released lines float to the pull-up level
  initial begin
    scl_low = 1'h0;
    sda_low = 1'h0;
  end

  // Quarter of the 800 ns bit time
  task automatic quarter();
    repeat (2) @(posedge clk);
  endtask

  // Release clock, then wait while the slave stretches it
  task automatic rise();
    int n;
    scl_low <= 1'h0;
    n = 0;
    @(posedge clk);
    while (scl !== 1'h1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic start_cond();
    sda_low <= 1'h1;
    quarter();
    scl_low <= 1'h1;
    quarter();
  endtask

  // Data changes only while the clock is low
  task automatic put_bit(input logic b, output logic got);
    sda_low <= ~b;
    quarter();
    rise();
    quarter();
    got = sda;
    quarter();
    scl_low <= 1'h1;
    quarter();
  endtask

  // Eight bits MSB first, then the slave's answer bit
  task automatic put_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], g);
    end
    put_bit(1'h1, ack);
  endtask

  task automatic stop_cond();
    sda_low <= 1'h1;
    quarter();
    rise();
    quarter();
    sda_low <= 1'h0;
    quarter();
  endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Slave receiver bench
// ****************************************************************
module tb;
  import tsr_pkg::*;
  logic        clk, rstn, av_rd, av_wr, deep_sleep, av_wait;
  logic [3:0]  av_addr;
  logic [31:0] av_wdata, av_rdata;
  logic        scl_oe, sda_oe, wake_req, m_scl, m_sda, a;
  wire logic   scl, sda;
  int          err_total, n_compared, cyc;

  // Open-drain wires with pull-ups
  assign scl = ~(scl_oe | m_scl);
  assign sda = ~(sda_oe | m_sda);

  tsr_slave_rx u_dut (
    .clk(clk), .rstn(rstn), .avs_address(av_addr), .avs_read(av_rd),
    .avs_write(av_wr), .avs_writedata(av_wdata), .avs_byteenable(4'hF),
    .avs_readdata(av_rdata), .avs_waitrequest(av_wait), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .deep_sleep(deep_sleep), .wake_req(wake_req));
  tsr_bus_master u_mst (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [3:0] ad, input logic [7:0] d,
                      output logic [7:0] q);
    av_addr <= ad;
    av_wdata <= {24'h000000, d};
    av_rd <= ~w;
    av_wr <= w;
    @(posedge clk);
    while (av_wait !== 1'h0) @(posedge clk);
    q = av_rdata[7:0];
    av_rd <= 1'h0;
    av_wr <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'h1, ad, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] ad, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    xfer(1'h0, ad, 8'h00, q);
    chk(q & m, e);
  endtask

  // Poll the flag a bounded number of times, then judge the code
  task automatic wait_flag(input logic [7:0] st);
    logic [7:0] q;
    int n;
    q = 8'h00;
    n = 0;
    while (q[7] !== 1'h1 && n < 300) begin
      xfer(1'h0, OFS_CONTROL, 8'h00, q);
      n++;
    end
    // A poll limit that runs out counts as a mismatch
    chk(q & 8'h80, 8'h80);
    rd_chk(OFS_STATUS, STATUS_MASK, st);
  endtask

  task automatic addr_byte(input logic [7:0] v, input logic [7:0] e);
    u_mst.start_cond();
    u_mst.put_byte(v, a);
    chk({7'h00, a}, e);
  endtask

  task automatic data_byte(input logic [7:0] ctl, input logic [7:0] v, input logic [7:0] e);
    wr(OFS_CONTROL, ctl);
    u_mst.put_byte(v, a);
    chk({7'h00, a}, e);
  endtask

  // Prescaler left nonzero so every later code check needs the mask
  task automatic t_regs();
    rd_chk(OFS_OWN_ADDR, 8'hFF, OWN_ADDR_RST);
    rd_chk(OFS_STATUS, STATUS_MASK, ST_IDLE);
    rd_chk(OFS_DATA, 8'hFF, DATA_RST);
    rd_chk(4'h2, 8'hFF, 8'h00);
    wr(OFS_STATUS, 8'h03);
    rd_chk(OFS_STATUS, 8'h07, 8'h03);
    rd_chk(OFS_STATUS, STATUS_MASK, ST_IDLE);
  endtask

  task automatic t_own();
    wr(OFS_OWN_ADDR, 8'hB4);
    wr(OFS_CONTROL, 8'h44);
    addr_byte(8'hB4, 8'h00);
    wait_flag(ST_OWN_W);
    chk({7'h00, scl_oe}, 8'h01);
    data_byte(8'hC4, 8'hA5, 8'h00);
    wait_flag(ST_OWN_ACK);
    rd_chk(OFS_DATA, 8'hFF, 8'hA5);
    data_byte(8'h84, 8'h3C, 8'h01);
    wait_flag(ST_OWN_NACK);
    rd_chk(OFS_DATA, 8'hFF, 8'h3C);
    wr(OFS_CONTROL, 8'hC4);
    u_mst.stop_cond();
  endtask

  task automatic t_gc();
    addr_byte(8'h00, 8'h01);
    u_mst.stop_cond();
    wr(OFS_OWN_ADDR, 8'hB5);
    addr_byte(8'h00, 8'h00);
    wait_flag(ST_GC_W);
    data_byte(8'hC4, 8'h11, 8'h00);
    wait_flag(ST_GC_ACK);
    data_byte(8'h84, 8'h22, 8'h01);
    wait_flag(ST_GC_NACK);
    wr(OFS_CONTROL, 8'h84);
    u_mst.stop_cond();
  endtask

  // Refusals, then recognition resumes and a stop ends the transfer
  task automatic t_refuse();
    addr_byte(8'hB4, 8'h01);
    u_mst.stop_cond();
    wr(OFS_CONTROL, 8'h44);
    addr_byte(8'hB5, 8'h01);
    u_mst.stop_cond();
    addr_byte(8'hB6, 8'h01);
    u_mst.stop_cond();
    addr_byte(8'hB4, 8'h00);
    wait_flag(ST_OWN_W);
    wr(OFS_CONTROL, 8'hC4);
    u_mst.stop_cond();
    wait_flag(ST_STOP_RX);
    wr(OFS_CONTROL, 8'hC4);
  endtask

  // Start request pending while addressed, then the block's own start
  task automatic t_arb();
    u_mst.start_cond();
    wr(OFS_CONTROL, 8'h64);
    u_mst.put_byte(8'hB4, a);
    chk({7'h00, a}, 8'h00);
    wait_flag(ST_ARB_OWN_W);
    data_byte(8'hA4, 8'h5A, 8'h01);
    wait_flag(ST_OWN_NACK);
    wr(OFS_CONTROL, 8'hE4);
    u_mst.stop_cond();
    wait_flag(ST_START_SENT);
    chk({6'h00, sda_oe, scl_oe}, 8'h03);
    wr(OFS_CONTROL, 8'hC4);
    // Bus stays ours until the generated stop has gone out
    while (sda_oe !== 1'h0) @(posedge clk);
    u_mst.quarter();
  endtask

  // Wake request and stretch only show once the ninth clock has been seen
  task automatic t_sleep();
    deep_sleep <= 1'h1;
    addr_byte(8'hB4, 8'h00);
    wait_flag(ST_OWN_W);
    chk({7'h00, wake_req}, 8'h01);
    chk({7'h00, scl_oe}, 8'h01);
    deep_sleep <= 1'h0;
    rd_chk(OFS_DATA, 8'hFF, 8'h5A);
    chk({7'h00, wake_req}, 8'h01);
    wr(OFS_CONTROL, 8'hC4);
    chk({7'h00, wake_req}, 8'h00);
    u_mst.stop_cond();
    wait_flag(ST_STOP_RX);
  endtask

  task automatic end_of_test();
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    {rstn, av_rd, av_wr, deep_sleep} = 4'h0;
    av_addr = 4'h0;
    av_wdata = 32'h00000000;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    t_regs();
    t_own();
    t_gc();
    t_refuse();
    t_arb();
    t_sleep();
    end_of_test();
  end
endmodule
